/* wdt_top.sv */
// Watchdog timer with change window, safety levels and Wishbone registers
//
// Notes on behaviour
// [R01] Enable and irq-enable pick stop, irq or reset
// [R02] Irq-enable, no enable, global enable: interrupt instead
// [R03] With enable set, time-out clears irq-enable
// [R04] Software re-arms irq-enable after each interrupt
// [R05] Change-unlock self-clears four cycles after set
// [R06] Enable clears only while change-unlock reads one
// [R07] Disable: write unlock plus enable, then zero
// [R08] Timeout select changes need change-unlock set
// [R09] Writing one enables; permitted zero disables
// [R10] Safety level two never allows disabling
// [R11] Safety level one: reset flag forces enable
// [R12] Select codes 0..9 give 2K to 1024K cycles
// [R13] Reserved select codes fall back to valid one
// [R14] Select MSB at bit 5, rest bits 2..0
// [R15] Irq-enable bit 6, unlock bit 4, enable bit 3
// [R16] Unused watchdog: software clears flag and enable
// [R17] Global enable gates interrupt, cleared when taken
// [R18] Watchdog reset sets sticky reset flag
`timescale 1ns/1ns
module wdt_top #(
  parameter int CNT_W = wdt_pkg::WDT_CNT_W
) (
  // Clock, reset, clock enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Watchdog oscillator pin and safety fuse level
  input wire logic wdt_osc_i,
  input wire logic [1:0] safety_level_i,
  // Core interrupt handshake
  input wire logic irq_taken_i,
  input wire logic return_from_interrupt_i,
  output logic wdt_irq_req_o,
  // System reset request and block interrupt
  output logic sys_reset_o,
  output logic irq_o
);

  // Oscillator pin synchroniser and edge detect
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  wire osc_tick;

  // Register state
  wdt_pkg::wdt_ctrl_t ctrl_q;
  wdt_pkg::wdt_ctrl_t ctrl_d;
  logic [2:0] unlock_cnt_q;
  logic [2:0] unlock_cnt_d;
  logic rst_flag_q;
  logic gie_q;
  logic pend_q;
  logic [wdt_pkg::WDT_EV_N-1:0] ev_stat_q;
  logic [wdt_pkg::WDT_EV_N-1:0] ev_en_q;
  logic [wdt_pkg::WDT_EV_N-1:0] ev_set;
  logic [wdt_pkg::WDT_EV_N-1:0] ev_clr;
  logic ack_q;
  logic [31:0] dat_q;
  logic sys_reset_q;
  logic irq_q;
  logic irq_req_q;

  // Bus decode
  wdt_pkg::wdt_wreq_t wreq;
  wire bus_req;
  wire byte0;
  wire wr_ctrl;
  wire wr_cause;
  wire wr_gie;
  wire wr_clr;
  wire wr_en;
  wire wr_restart;
  logic [31:0] rd_mux;

  // Watchdog behaviour terms
  wire enable_eff;
  wire running;
  wire timeout;
  wire to_irq;
  wire to_reset;
  wire unlocked;
  wire [3:0] wr_tsel;
  wire [3:0] tsel_legal;
  wire [CNT_W-1:0] count;
  wire restart;

  // Two stages before any logic looks at the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else if (ce_i) begin
      osc_s1_q <= wdt_osc_i;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign osc_tick = osc_s2_q && !osc_s3_q;

  // Write lands on the edge where the master sees ack
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign byte0 = wb_sel_i[0];
  assign wreq.wr = bus_req && wb_we_i && ack_q && byte0;
  assign wreq.ofs = wb_adr_i;
  assign wreq.data = wb_dat_i[7:0];
  assign wr_ctrl = wreq.wr && (wreq.ofs == wdt_pkg::WDT_OFS_CTRL);
  assign wr_cause = wreq.wr && (wreq.ofs == wdt_pkg::WDT_OFS_CAUSE);
  assign wr_gie = wreq.wr && (wreq.ofs == wdt_pkg::WDT_OFS_GIE);
  assign wr_clr = wreq.wr && (wreq.ofs == wdt_pkg::WDT_OFS_IRQ_CLR);
  assign wr_en = wreq.wr && (wreq.ofs == wdt_pkg::WDT_OFS_IRQ_EN);
  assign wr_restart = wreq.wr && (wreq.ofs == wdt_pkg::WDT_OFS_RESTART);

  // Split select field gathered from the written byte
  assign wr_tsel = {wreq.data[wdt_pkg::WDT_BIT_TSEL_HI],
                    wreq.data[wdt_pkg::WDT_BIT_TSEL_LO+2:wdt_pkg::WDT_BIT_TSEL_LO]}; // [R14]
  // Reserved codes clamp to the longest valid setting
  assign tsel_legal = (wr_tsel > wdt_pkg::WDT_TSEL_MAX) ? wdt_pkg::WDT_TSEL_MAX
                                                       : wr_tsel; // [R13]

  assign unlocked = ctrl_q.unlock;

  // Fuse level and reset flag can hold the watchdog on
  assign enable_eff = ctrl_q.enable
                   || (safety_level_i == wdt_pkg::WDT_SAFETY_2)
                   || ((safety_level_i == wdt_pkg::WDT_SAFETY_1) && rst_flag_q); // [R10] [R11]
  assign running = enable_eff || ctrl_q.irq_en; // [R01]
  assign to_irq = timeout && ctrl_q.irq_en; // [R01]
  assign to_reset = timeout && enable_eff && !ctrl_q.irq_en; // [R01] [R03]
  // Enabling from stopped starts a fresh period
  assign restart = wr_restart || to_reset || (!running && ctrl_d.enable);

  wdt_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tick_i(osc_tick),
    .run_i(running),
    .restart_i(restart),
    .tsel_i(ctrl_q.tsel),
    .timeout_o(timeout),
    .count_o(count)
  );

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    unlock_cnt_d = unlock_cnt_q;
    if (unlock_cnt_q != 3'h0) begin
      unlock_cnt_d = unlock_cnt_q - 3'h1;
      if (unlock_cnt_q == 3'h1) begin
        ctrl_d.unlock = 1'b0; // [R05]
      end
    end
    // Hardware drops irq-enable so the next time-out resets
    if (to_irq && enable_eff) begin
      ctrl_d.irq_en = 1'b0; // [R03]
    end
    if (wr_ctrl) begin
      // A software set of irq-enable wins over the hardware clear
      ctrl_d.irq_en = wreq.data[wdt_pkg::WDT_BIT_IRQ_EN] | ctrl_d.irq_en; // [R04]
      if (!wreq.data[wdt_pkg::WDT_BIT_IRQ_EN]) begin
        ctrl_d.irq_en = 1'b0;
      end
      if (wreq.data[wdt_pkg::WDT_BIT_ENABLE]) begin
        ctrl_d.enable = 1'b1; // [R09]
      end else if (unlocked && safety_level_i != wdt_pkg::WDT_SAFETY_2) begin
        ctrl_d.enable = 1'b0; // [R06] [R07] [R09] [R10]
      end
      if (unlocked) begin
        ctrl_d.tsel = tsel_legal; // [R08]
      end
      if (wreq.data[wdt_pkg::WDT_BIT_UNLOCK]) begin
        ctrl_d.unlock = 1'b1;
        unlock_cnt_d = wdt_pkg::WDT_UNLOCK_CYCLES; // [R05]
      end else begin
        ctrl_d.unlock = 1'b0;
        unlock_cnt_d = 3'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q.irq_en <= wdt_pkg::WDT_IRQ_EN_RST;
      ctrl_q.unlock <= 1'b0;
      ctrl_q.enable <= wdt_pkg::WDT_ENABLE_RST;
      ctrl_q.tsel <= wdt_pkg::WDT_TSEL_RST;
      unlock_cnt_q <= 3'h0;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      unlock_cnt_q <= unlock_cnt_d;
    end
  end

  // Sticky reset flag: set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (to_reset) begin
        rst_flag_q <= 1'b1; // [R18]
      end else if (wr_cause && !wreq.data[wdt_pkg::WDT_BIT_RST_FLAG]) begin
        rst_flag_q <= 1'b0; // [R16]
      end
    end
  end

  // Global interrupt enable and pending watchdog interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gie_q <= wdt_pkg::WDT_GIE_RST;
      pend_q <= 1'b0;
      irq_req_q <= 1'b0;
    end else if (ce_i) begin
      if (irq_taken_i) begin
        gie_q <= 1'b0; // [R17]
      end else if (return_from_interrupt_i) begin
        gie_q <= 1'b1; // [R17]
      end else if (wr_gie) begin
        gie_q <= wreq.data[wdt_pkg::WDT_BIT_GIE];
      end
      if (to_irq) begin
        pend_q <= 1'b1;
      end else if (irq_taken_i && irq_req_q) begin
        pend_q <= 1'b0;
      end
      // No vector without the global enable; pending waits for it
      irq_req_q <= (pend_q || to_irq) && gie_q && !irq_taken_i; // [R02] [R17]
    end
  end

  // Event status, enable and interrupt line
  assign ev_set[wdt_pkg::WDT_BIT_EV_IRQ] = to_irq;
  assign ev_set[wdt_pkg::WDT_BIT_EV_RST] = to_reset;
  assign ev_clr = wr_clr ? wreq.data[wdt_pkg::WDT_EV_N-1:0] : wdt_pkg::WDT_EV_RST;

  generate
    for (genvar i = 0; i < wdt_pkg::WDT_EV_N; i++) begin : g_ev
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ev_stat_q[i] <= 1'b0;
          ev_en_q[i] <= 1'b0;
        end else if (ce_i) begin
          ev_stat_q[i] <= ev_set[i] | (ev_stat_q[i] & ~ev_clr[i]);
          if (wr_en) begin
            ev_en_q[i] <= wreq.data[i];
          end
        end
      end
    end
  endgenerate

  // Reset request is one cycle wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      sys_reset_q <= to_reset; // [R01]
      irq_q <= |(ev_stat_q & ev_en_q);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0;
    case (wb_adr_i)
      wdt_pkg::WDT_OFS_CTRL: begin
        rd_mux[wdt_pkg::WDT_BIT_IRQ_EN] = ctrl_q.irq_en; // [R15]
        rd_mux[wdt_pkg::WDT_BIT_TSEL_HI] = ctrl_q.tsel[3]; // [R14]
        rd_mux[wdt_pkg::WDT_BIT_UNLOCK] = ctrl_q.unlock; // [R15]
        rd_mux[wdt_pkg::WDT_BIT_ENABLE] = enable_eff; // [R11] [R15]
        rd_mux[wdt_pkg::WDT_BIT_TSEL_LO+2:wdt_pkg::WDT_BIT_TSEL_LO] = ctrl_q.tsel[2:0];
      end
      wdt_pkg::WDT_OFS_CAUSE: begin
        rd_mux[wdt_pkg::WDT_BIT_RST_FLAG] = rst_flag_q;
      end
      wdt_pkg::WDT_OFS_GIE: begin
        rd_mux[wdt_pkg::WDT_BIT_GIE] = gie_q;
      end
      wdt_pkg::WDT_OFS_IRQ_STAT: begin
        rd_mux[wdt_pkg::WDT_EV_N-1:0] = ev_stat_q;
      end
      wdt_pkg::WDT_OFS_IRQ_EN: begin
        rd_mux[wdt_pkg::WDT_EV_N-1:0] = ev_en_q;
      end
      wdt_pkg::WDT_OFS_COUNT: begin
        rd_mux[CNT_W-1:0] = count;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  // One wait state: ack one cycle after the request appears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else if (ce_i) begin
      ack_q <= bus_req && !ack_q;
      if (bus_req && !ack_q && !wb_we_i) begin
        dat_q <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign sys_reset_o = sys_reset_q;
  assign irq_o = irq_q;
  assign wdt_irq_req_o = irq_req_q;

endmodule

/* wdt_pkg.sv */
// Package with register map, field layout and timing constants of the watchdog
package wdt_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] WDT_OFS_CTRL = 8'h00;
  localparam logic [7:0] WDT_OFS_CAUSE = 8'h04;
  localparam logic [7:0] WDT_OFS_GIE = 8'h08;
  localparam logic [7:0] WDT_OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] WDT_OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] WDT_OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] WDT_OFS_RESTART = 8'h18;
  localparam logic [7:0] WDT_OFS_COUNT = 8'h1c;

  // Control register bit positions
  localparam int WDT_BIT_IRQ_EN = 6;
  localparam int WDT_BIT_TSEL_HI = 5;
  localparam int WDT_BIT_UNLOCK = 4;
  localparam int WDT_BIT_ENABLE = 3;
  localparam int WDT_BIT_TSEL_LO = 0;

  // Other register bit positions
  localparam int WDT_BIT_RST_FLAG = 3;
  localparam int WDT_BIT_GIE = 7;
  localparam int WDT_BIT_EV_IRQ = 0;
  localparam int WDT_BIT_EV_RST = 1;
  localparam int WDT_EV_N = 2;

  // Reset values
  localparam logic [3:0] WDT_TSEL_RST = 4'h0;
  localparam logic WDT_ENABLE_RST = 1'b0;
  localparam logic WDT_IRQ_EN_RST = 1'b0;
  localparam logic WDT_GIE_RST = 1'b0;
  localparam logic [WDT_EV_N-1:0] WDT_EV_RST = 2'h0;

  // Timeout select: 2K oscillator cycles at code 0, doubling to code 9
  localparam int WDT_BASE_CYCLES = 2048;
  localparam logic [3:0] WDT_TSEL_MAX = 4'h9;
  localparam int WDT_CNT_W = 21;

  // Change window length in system clock cycles
  localparam logic [2:0] WDT_UNLOCK_CYCLES = 3'h4;

  // Safety levels
  localparam logic [1:0] WDT_SAFETY_0 = 2'h0;
  localparam logic [1:0] WDT_SAFETY_1 = 2'h1;
  localparam logic [1:0] WDT_SAFETY_2 = 2'h2;

  // Watchdog control fields
  typedef struct packed {
    logic irq_en;
    logic unlock;
    logic enable;
    logic [3:0] tsel;
  } wdt_ctrl_t;

  // Decoded bus write request
  typedef struct packed {
    logic wr;
    logic [7:0] ofs;
    logic [7:0] data;
  } wdt_wreq_t;

endpackage

/* wdt_counter.sv */
// Time-out counter stepped by watchdog oscillator ticks
`timescale 1ns/1ns
module wdt_counter #(
  parameter int CNT_W = wdt_pkg::WDT_CNT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [3:0] tsel_i,
  // Status
  output logic timeout_o,
  output logic [CNT_W-1:0] count_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic timeout_q;
  logic [CNT_W-1:0] limit;
  wire last;

  // Length doubles with each code step
  assign limit = CNT_W'(wdt_pkg::WDT_BASE_CYCLES) << tsel_i; // [R12]
  assign last = (cnt_q >= limit - CNT_W'(1));

  always_comb begin
    cnt_d = cnt_q;
    if (restart_i || !run_i) begin
      cnt_d = '0;
    end else if (tick_i) begin
      cnt_d = last ? '0 : cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      timeout_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      timeout_q <= run_i && !restart_i && tick_i && last;
    end
  end

  assign timeout_o = timeout_q;
  assign count_o = cnt_q;

endmodule

/* wdt_top_asserts.sv */
// Port-level checker of the watchdog block
`timescale 1ns/1ns
module wdt_top_asserts #(
  parameter int CNT_W = wdt_pkg::WDT_CNT_W
) (
  // Inputs of the block
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wdt_osc_i,
  input wire logic [1:0] safety_level_i,
  input wire logic irq_taken_i,
  input wire logic return_from_interrupt_i,
  // Outputs of the block
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wdt_irq_req_o,
  input wire logic sys_reset_o,
  input wire logic irq_o
);
  logic osc_q;
  logic [11:0] tick_q;
  logic [11:0] tick_d;

  // Pin edges since last reset; counts early, so only a lower bound is safe
  assign tick_d = (wdt_osc_i && !osc_q && tick_q != 12'hfff) ? tick_q + 12'h1 : tick_q;

  always_ff @(posedge clk_i) begin
    osc_q <= wdt_osc_i;
    tick_q <= (rst_i || sys_reset_o) ? 12'h000 : tick_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_ACK_PULSE: assert property (s_req |=> s_ack_pulse)
    else $error("ack not one pulse after request");
  AST_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // Only the counter word may use bits above the low byte
  AST_RDATA_HI: assert property (wb_ack_o |-> wb_dat_o[31:CNT_W] == '0
    && (wb_dat_o[CNT_W-1:8] == '0 || wb_adr_i == wdt_pkg::WDT_OFS_COUNT))
    else $error("upper read bits set");
  AST_RST_PULSE: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("reset request too long");
  AST_RST_MIN: assert property (sys_reset_o |-> tick_q >= 12'h7fe)
    else $error("reset before shortest period");
  AST_TAKEN: assert property (irq_taken_i |-> ##2 !wdt_irq_req_o)
    else $error("request kept after taken");
  AST_EXCL: assert property ($rose(wdt_irq_req_o) |-> !sys_reset_o && !$past(sys_reset_o))
    else $error("interrupt and reset together");
  AST_IRQO_FALL: assert property ($fell(irq_o) |-> $past(wb_we_i && wb_ack_o)
    || $past(wb_we_i && wb_ack_o, 2))
    else $error("irq dropped without write");
endmodule

bind wdt_top wdt_top_asserts #(.CNT_W(CNT_W)) u_wdt_top_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wdt_osc_i(wdt_osc_i), .safety_level_i(safety_level_i), .irq_taken_i(irq_taken_i),
  .return_from_interrupt_i(return_from_interrupt_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wdt_irq_req_o(wdt_irq_req_o), .sys_reset_o(sys_reset_o),
  .irq_o(irq_o)
);

/* wdt_tb_top.sv */
// Self-checking testbench of the watchdog block
`timescale 1ns/1ns
module wdt_tb_top;
  logic clk_i, rst, cyc, we, take, return_from_interrupt, ack, req, srst, irq;
  logic [7:0] adr, dat, r;
  logic [1:0] lvl;
  logic [1:0] osc_q = 2'h0;
  logic [31:0] rdat;
  int err_count = 0;
  int compares = 0;
  int rst_seen = 0;
  int n;

  wdt_top u_wdt_top (
    .clk_i(clk_i), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, dat}), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wdt_osc_i(osc_q[1]), .safety_level_i(lvl), .irq_taken_i(take),
    .return_from_interrupt_i(return_from_interrupt), .wdt_irq_req_o(req), .sys_reset_o(srst), .irq_o(irq)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Oscillator tick every four clocks keeps time-outs near 8K cycles
  always @(posedge clk_i) begin
    osc_q <= osc_q + 2'h1;
    if (srst === 1'b1) rst_seen++;
  end

  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("unexpected at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) hang();
    r = rdat[7:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    cmp(r, exp);
  endtask

  task automatic wait_ev(input logic on_rst, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((on_rst ? srst : req) !== 1'b1 && n < lim);
    if (n >= lim) hang();
  endtask

  task automatic pulse(input logic is_take);
    if (is_take) take <= 1'b1;
    else return_from_interrupt <= 1'b1;
    @(posedge clk_i);
    take <= 1'b0;
    return_from_interrupt <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Second write lands inside the change window
  task automatic unlock_off();
    wb(1'b1, 8'h00, 8'h18);
    wb(1'b1, 8'h00, 8'h00);
  endtask

  task automatic t_regs();
    chk(8'h00, 8'h00);
    chk(8'h04, 8'h00);
    wb(1'b1, 8'h40, 8'hff);
    chk(8'h40, 8'h00);
    wb(1'b1, 8'h00, 8'h10);
    // Reads land on the last window cycle and three cycles after it
    repeat (2) @(posedge clk_i);
    chk(8'h00, 8'h10);
    chk(8'h00, 8'h00);
    wb(1'b1, 8'h00, 8'h18);
    wb(1'b1, 8'h00, 8'h2f);
    chk(8'h00, 8'h29);
    wb(1'b1, 8'h00, 8'h0a);
    chk(8'h00, 8'h29);
    wb(1'b1, 8'h00, 8'h00);
    chk(8'h00, 8'h29);
    unlock_off();
    chk(8'h00, 8'h00);
  endtask

  task automatic t_irq();
    wb(1'b1, 8'h14, 8'h03);
    wb(1'b1, 8'h08, 8'h80);
    wb(1'b1, 8'h00, 8'h40);
    wait_ev(1'b0, 9000);
    chk(8'h0c, 8'h01);
    cmp({7'h0, irq}, 8'h01);
    chk(8'h00, 8'h40);
    pulse(1'b1);
    cmp({7'h0, req}, 8'h00);
    chk(8'h08, 8'h00);
    wb(1'b1, 8'h10, 8'h01);
    @(posedge clk_i);
    cmp({7'h0, irq}, 8'h00);
    n = 0;
    repeat (9000) begin
      @(posedge clk_i);
      if (req === 1'b1) n++;
    end
    cmp(8'(n), 8'h00);
    chk(8'h0c, 8'h01);
    pulse(1'b0);
    cmp({7'h0, req}, 8'h01);
    cmp(8'(rst_seen), 8'h00);
    pulse(1'b1);
    pulse(1'b0);
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h10, 8'h03);
  endtask

  task automatic t_comb();
    wb(1'b1, 8'h00, 8'h48);
    wait_ev(1'b0, 9000);
    cmp(8'((n + 32) / 64), 8'h80);
    chk(8'h00, 8'h08);
    pulse(1'b1);
    pulse(1'b0);
    // Re-armed irq-enable turns the next time-out into an interrupt again
    wb(1'b1, 8'h00, 8'h48);
    wait_ev(1'b0, 9000);
    cmp(8'(rst_seen), 8'h00);
    chk(8'h00, 8'h08);
    pulse(1'b1);
    wait_ev(1'b1, 9000);
    chk(8'h04, 8'h08);
    chk(8'h0c, 8'h03);
  endtask

  task automatic t_safe();
    lvl <= 2'h1;
    unlock_off();
    chk(8'h00, 8'h08);
    wb(1'b1, 8'h04, 8'h00);
    chk(8'h04, 8'h00);
    unlock_off();
    chk(8'h00, 8'h00);
    rst <= 1'b1;
    lvl <= 2'h2;
    repeat (8) @(posedge clk_i);
    rst <= 1'b0;
    @(posedge clk_i);
    chk(8'h00, 8'h08);
    unlock_off();
    chk(8'h00, 8'h08);
    // Without the restart the counter would be well past one tick here
    repeat (40) @(posedge clk_i);
    wb(1'b1, 8'h18, 8'h00);
    wb(1'b0, 8'h1c, 8'h00);
    cmp(8'(rdat >> 1), 8'h00);
  endtask

  initial begin
    rst <= 1'b1;
    cyc <= 1'b0;
    we <= 1'b0;
    adr <= 8'h00;
    dat <= 8'h00;
    lvl <= 2'h0;
    take <= 1'b0;
    return_from_interrupt <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_irq();
    t_comb();
    t_safe();
    report_and_stop();
  end
endmodule
